// ==== pkg/prhg_pkg.sv ====
package prhg_pkg;
  // output word width
  localparam int WORD_W          = 16;
  // start-up window length, not used: the gate runs its start-up window on WIN_BITS
  localparam int STARTUP_BITS    = 1024;
  // bits in one periodic test window
  localparam int PERIODIC_BITS   = 1024;
  // run length of equal raw bits at which total failure is declared
  localparam int STUCK_RUN_MAX   = 32;
  // tolerated ones count per window, lower and upper bound
  localparam int ONES_LO         = 448;
  localparam int ONES_HI         = 576;
  // counter widths
  localparam int WIN_CNT_W       = 11;
  localparam int RUN_CNT_W       = 6;
  localparam int BIT_CNT_W       = 4;
  // synchroniser depth for the raw bit and its strobe
  localparam int SYNC_STAGES     = 3;
  // gate states
  typedef enum logic [1:0] {
    PRHG_OFF,
    PRHG_STARTUP,
    PRHG_RUN,
    PRHG_FAIL
  } prhg_state_t;
endpackage

// ==== core/prhg_gate.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] total failure detected at start, blocks output
// [RULE2] words with post-failure raw bits withheld
// [RULE3] online test at start and during operation
// [RULE4] no output before start-up test passes
// [RULE5] online test repeats continuously in windows
// [RULE6] each delivered number is 16 bits
// [RULE7] test logic reports pass/fail to software
// [RULE8] any failure reports error, shuts generator
// [RULE9] software runs its own total-failure check
// [RULE10] software applies cryptographic post-processing
// [RULE11] failure sticks until re-enable or reset
// [RULE12] valid only for healthy, complete fresh word
module prhg_gate
  import prhg_pkg::*;
#(
  parameter int WIN_BITS  = PERIODIC_BITS,
  parameter int RUN_MAX   = STUCK_RUN_MAX,
  parameter int LO_BOUND  = ONES_LO,
  parameter int HI_BOUND  = ONES_HI
) (
  // clock, enable, reset
  input  wire logic              clk_sys,
  input  wire logic              clk_en,
  input  wire logic              rst_b,
  // raw entropy source pins
  input  wire logic              raw_bit,
  input  wire logic              raw_tgl,
  output logic                   src_run,
  // software control
  input  wire logic              gen_enable,
  // random word output
  output logic [WORD_W-1:0]      rnd_word,
  output logic                   rnd_valid,
  // health reporting
  output logic                   test_done,
  output logic                   test_pass,
  output logic                   fail_total,
  output logic                   fail_stat
);

  initial begin
    if (WIN_BITS < 2 || WIN_BITS >= (1 << WIN_CNT_W)) $error("window out of range");
    if (RUN_MAX < 2 || RUN_MAX >= (1 << RUN_CNT_W)) $error("run limit out of range");
    if (LO_BOUND > HI_BOUND || HI_BOUND > WIN_BITS) $error("bad ones bounds");
  end

  // synchroniser stages for raw bit and toggle strobe
  logic [SYNC_STAGES-1:0]  bit_sync_r;
  logic [SYNC_STAGES-1:0]  tgl_sync_r;
  logic                    tgl_seen_r;      // last accepted toggle level
  logic                    bit_val_r;       // last accepted raw bit
  logic                    en_d_r;          // enable delayed, edge detect
  prhg_state_t             state_r;
  logic [WIN_CNT_W-1:0]    win_cnt_r;       // bits in current window
  logic [WIN_CNT_W-1:0]    ones_cnt_r;      // ones in current window
  logic [RUN_CNT_W-1:0]    run_cnt_r;       // equal-bit run length
  logic                    prev_bit_r;      // previous raw bit
  logic [WORD_W-1:0]       shift_r;         // word assembly
  logic [BIT_CNT_W-1:0]    bit_cnt_r;       // bits in assembly

  logic new_bit;    // a fresh raw bit accepted this cycle
  logic cur_bit;    // its value
  logic stuck;      // run limit reached
  logic win_end;    // window closes this bit
  logic win_ok;     // ones count inside bounds
  logic rise_en;    // software re-enable edge
  logic [WIN_CNT_W-1:0] ones_nxt;

  // a change counts once stages two and three agree
  assign new_bit  = (tgl_sync_r[1] == tgl_sync_r[2]) && (tgl_sync_r[2] != tgl_seen_r);
  assign cur_bit  = (bit_sync_r[1] == bit_sync_r[2]) ? bit_sync_r[2] : bit_val_r;
  assign stuck    = new_bit && (cur_bit == prev_bit_r)
                    && (run_cnt_r == RUN_CNT_W'(RUN_MAX - 1));
  // [RULE3] window close at start-up and in run
  assign win_end  = new_bit && (win_cnt_r == WIN_CNT_W'(WIN_BITS - 1));
  assign ones_nxt = ones_cnt_r + WIN_CNT_W'(cur_bit);
  assign win_ok   = (ones_nxt >= WIN_CNT_W'(LO_BOUND)) && (ones_nxt <= WIN_CNT_W'(HI_BOUND));
  assign rise_en  = gen_enable && !en_d_r;

  // pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_sync_r <= '0;
      tgl_sync_r <= '0;
    end else if (clk_en) begin
      bit_sync_r <= {bit_sync_r[SYNC_STAGES-2:0], raw_bit};
      tgl_sync_r <= {tgl_sync_r[SYNC_STAGES-2:0], raw_tgl};
    end
  end

  // accepted toggle level, bit value, enable history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen_r <= 1'b0;
      bit_val_r  <= 1'b0;
      en_d_r     <= 1'b0;
    end else if (clk_en) begin
      if (new_bit) begin
        tgl_seen_r <= tgl_sync_r[2];
      end
      bit_val_r <= cur_bit;
      en_d_r    <= gen_enable;
    end
  end

  // health state machine
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PRHG_OFF;
    end else if (clk_en) begin
      case (state_r)
        PRHG_OFF: begin
          if (gen_enable) begin
            state_r <= PRHG_STARTUP;
          end
        end
        PRHG_STARTUP: begin
          if (!gen_enable) begin
            state_r <= PRHG_OFF;
          // [RULE1] stuck source at start
          end else if (stuck) begin
            state_r <= PRHG_FAIL;
          // [RULE4] start-up window verdict
          end else if (win_end) begin
            state_r <= win_ok ? PRHG_RUN : PRHG_FAIL;
          end
        end
        PRHG_RUN: begin
          if (!gen_enable) begin
            state_r <= PRHG_OFF;
          // [RULE8] shut down on failure
          end else if (stuck || (win_end && !win_ok)) begin
            state_r <= PRHG_FAIL;
          end
        end
        PRHG_FAIL: begin
          // [RULE11] sticky until re-enable
          if (rise_en) begin
            state_r <= PRHG_STARTUP;
          end
        end
        default: state_r <= PRHG_OFF;
      endcase
    end
  end

  // window, ones and run counters
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt_r  <= '0;
      ones_cnt_r <= '0;
      run_cnt_r  <= '0;
      prev_bit_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == PRHG_OFF || state_r == PRHG_FAIL) begin
        win_cnt_r  <= '0;
        ones_cnt_r <= '0;
        run_cnt_r  <= '0;
      end else if (new_bit) begin
        prev_bit_r <= cur_bit;
        // [RULE5] back-to-back test windows
        if (win_end) begin
          win_cnt_r  <= '0;
          ones_cnt_r <= '0;
        end else begin
          win_cnt_r  <= win_cnt_r + 1'b1;
          ones_cnt_r <= ones_nxt;
        end
        // run length, zero means no bit since restart
        run_cnt_r <= (cur_bit == prev_bit_r && run_cnt_r != '0) ? run_cnt_r + 1'b1
                                                                 : RUN_CNT_W'(1);
      end
    end
  end

  // word assembly and delivery
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shift_r   <= '0;
      bit_cnt_r <= '0;
      rnd_word  <= '0;
      rnd_valid <= 1'b0;
    end else if (clk_en) begin
      rnd_valid <= 1'b0;
      // [RULE2] discard partial word on failure
      if (state_r != PRHG_RUN || !gen_enable || stuck || (win_end && !win_ok)) begin
        bit_cnt_r <= '0;
      end else if (new_bit) begin
        shift_r <= {shift_r[WORD_W-2:0], cur_bit};
        // [RULE6] sixteen bits per word
        if (bit_cnt_r == BIT_CNT_W'(WORD_W - 1)) begin
          bit_cnt_r <= '0;
          rnd_word  <= {shift_r[WORD_W-2:0], cur_bit};
          // [RULE12] valid on healthy fresh word
          rnd_valid <= 1'b1;
        end else begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
      end
    end
  end

  // health reporting to software
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      test_done  <= 1'b0;
      test_pass  <= 1'b0;
      fail_total <= 1'b0;
      fail_stat  <= 1'b0;
      src_run    <= 1'b0;
    end else if (clk_en) begin
      test_done <= 1'b0;
      src_run   <= gen_enable && (state_r != PRHG_FAIL) && !rise_en ? 1'b1 : 1'b0;
      if (rise_en) begin
        fail_total <= 1'b0;
        fail_stat  <= 1'b0;
        test_pass  <= 1'b0;
      end else if (state_r == PRHG_STARTUP || state_r == PRHG_RUN) begin
        // [RULE7] report each verdict
        if (stuck) begin
          fail_total <= 1'b1;
          test_done  <= 1'b1;
          test_pass  <= 1'b0;
        end else if (win_end) begin
          test_done <= 1'b1;
          test_pass <= win_ok;
          if (!win_ok) begin
            fail_stat <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ==== tb/prhg_gate_chk.sv ====
`timescale 1ns/10ps
// port checker for the health gate
module prhg_gate_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // control and status
  input wire logic gen_enable,
  input wire logic src_run,
  input wire logic rnd_valid,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic fail_total,
  input wire logic fail_stat
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !clk_en);
  // enable held, so no restart edge
  sequence s_hold; gen_enable[*3]; endsequence
  // verdict pulse then a failing level
  sequence s_bad; test_done ##1 !test_pass; endsequence
  AST_VALID_GATED: assert property (rnd_valid |-> test_pass && !fail_total && !fail_stat)
    else $error("word delivered while unhealthy");
  AST_VALID_PULSE: assert property (rnd_valid |=> !rnd_valid)
    else $error("word strobe longer than one cycle");
  AST_DONE_PULSE: assert property (test_done |=> !test_done)
    else $error("verdict strobe longer than one cycle");
  AST_TOTAL_STICKY: assert property (s_hold ##0 fail_total |=> fail_total)
    else $error("total failure flag dropped");
  AST_STAT_STICKY: assert property (s_hold ##0 fail_stat |=> fail_stat)
    else $error("statistical failure flag dropped");
  AST_SRC_STOP: assert property ($rose(fail_total || fail_stat) |-> ##[0:1] !src_run)
    else $error("source still running after failure");
  AST_FAIL_VERDICT: assert property (s_bad |-> fail_total || fail_stat)
    else $error("failed verdict without failure flag");
  AST_OFF_QUIET: assert property ((!gen_enable)[*2] |-> !src_run && !rnd_valid)
    else $error("activity while disabled");
  AST_CLEAR: assert property ($rose(gen_enable) |-> ##[1:2] !fail_total && !fail_stat)
    else $error("flags not cleared by re-enable");
endmodule
bind prhg_gate prhg_gate_chk prhg_gate_chk_inst (.clk_sys, .rst_b, .clk_en, .gen_enable, .src_run,
  .rnd_valid, .test_done, .test_pass, .fail_total, .fail_stat);

// ==== tb/prhg_src.sv ====
`timescale 1ns/10ps
// entropy source stand-in, one raw bit every four cycles
module prhg_src (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // run request and pattern choice
  input  wire logic       go,
  input  wire logic [1:0] mode,
  // raw pins
  output logic            raw_bit,
  output logic            raw_tgl
);
  logic [15:0] pat;   // balanced, stuck or biased pattern
  logic [5:0]  cnt_r; // phase and bit index
  assign pat = (mode == 2'h0) ? 16'hA5C3 : (mode == 2'h1) ? 16'hFFFF : 16'hFEFE;
  // bits only while running, restart aligned
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= 6'h00;
      raw_bit <= 1'b0;
      raw_tgl <= 1'b0;
    end else if (!go) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
      if (cnt_r[1:0] == 2'h3) begin
        raw_bit <= pat[4'hF - cnt_r[5:2]];
        raw_tgl <= ~raw_tgl;
      end
    end
  end
endmodule

// ==== tb/physical_rng_health_gate_test.sv ====
`timescale 1ns/10ps
// bench for the health gate
module physical_rng_health_gate_test
  import prhg_pkg::*;
();
  logic clk_sys, clk_en, rst_b, gen_enable, raw_bit, raw_tgl, src_run;
  logic rnd_valid, test_done, test_pass, fail_total, fail_stat;
  logic [1:0]        mode;     // source pattern
  logic [WORD_W-1:0] rnd_word; // delivered word
  logic [15:0]       nv, nv0;  // word strobes seen
  int                error_cnt, n_tests;
  prhg_gate #(.WIN_BITS(32), .RUN_MAX(8), .LO_BOUND(8), .HI_BOUND(24)) prhg_gate_inst (
    .clk_sys, .clk_en, .rst_b, .raw_bit, .raw_tgl, .src_run, .gen_enable,
    .rnd_word, .rnd_valid, .test_done, .test_pass, .fail_total, .fail_stat);
  prhg_src prhg_src_inst (.clk_sys, .rst_b, .go(src_run), .mode, .raw_bit, .raw_tgl);
  always #2 clk_sys = ~clk_sys;
  // count delivered words
  always @(posedge clk_sys) if (rnd_valid === 1'b1) nv <= nv + 16'h0001;
  task complete_run;
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task ck(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // bounded wait: 0 for a word, 1 for a verdict
  task wt(input int k);
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      if ((k == 0) ? rnd_valid === 1'b1 : test_done === 1'b1) return;
    end
    error_cnt++;
    complete_run;
  endtask
  // restart with a given source pattern
  task restart(input logic [1:0] m);
    gen_enable = 1'b0;
    cyc(3);
    mode = m;
    gen_enable = 1'b1;
  endtask
  task t_start;
    restart(2'h0);
    wt(1);
    ck(nv, 16'h0000);
    ck(test_pass, 1'b1);
    wt(0);
    ck(rnd_word, 16'hA5C3);
    ck(rnd_word == 16'h0000 || rnd_word == 16'hFFFF, 1'b0);
    ck(rnd_word ^ 16'hA5C3, 16'h0000);
    wt(0);
    ck(rnd_word, 16'hA5C3);
    wt(1);
    ck(test_pass, 1'b1);
  endtask
  task t_stuck;
    mode = 2'h1;
    wt(1);
    cyc(2);
    ck({test_pass, fail_total, fail_stat, src_run}, 4'h4);
    nv0 = nv;
    cyc(60);
    ck(nv, nv0);
    gen_enable = 1'b0;
    cyc(4);
    ck(fail_total, 1'b1);
  endtask
  task t_renable;
    // frozen clock enable: re-enable edge must wait
    clk_en = 1'b0;
    restart(2'h0);
    cyc(3);
    ck({fail_total, src_run}, 2'h2);
    clk_en = 1'b1;
    cyc(3);
    ck({fail_total, test_pass}, 2'h0);
    wt(1);
    ck(test_pass, 1'b1);
    restart(2'h1);
    nv0 = nv;
    wt(1);
    cyc(2);
    ck(fail_total, 1'b1);
    ck(nv, nv0);
  endtask
  task t_bias;
    restart(2'h2);
    nv0 = nv;
    wt(1);
    cyc(2);
    ck({fail_stat, fail_total, test_pass}, 3'h4);
    ck(nv, nv0);
    rst_b = 1'b0;
    cyc(2);
    ck({fail_stat, src_run, test_pass}, 3'h0);
    rst_b = 1'b1;
    cyc(2);
    ck({fail_stat, fail_total, src_run}, 3'h1);
  endtask
  initial begin
    clk_sys = 1'b0;
    clk_en = 1'b1;
    rst_b = 1'b0;
    gen_enable = 1'b0;
    mode = 2'h0;
    nv = 16'h0000;
    error_cnt = 0;
    n_tests = 0;
    cyc(8);
    rst_b = 1'b1;
    t_start;
    t_stuck;
    t_renable;
    t_bias;
    complete_run;
  end
endmodule
